/* hw/fbp_port.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - four pins, each with own direction bit
// - port register: low nibble data, high direction
// - pin zero open-drain low; others push-pull
// - output types fixed in hardware, no option
// - pins zero/one: level or single edge detect
// - pins two/three: falling, rising or both edges
// - selected pin two/three event pulses timer count
// - selected pin zero/two event strobes low capture
// - pin zero level mode repeats low capture
// - selected pin one/three event strobes high capture
// - pin one level mode repeats high capture
// - flag and enable on sources 0-2 wake
// - after wake, light standby until interrupt accepted
// - level on pins zero/one sets flag in standby
// - pin two edge blocked by standby entry level
// - pins zero/one wake only in level mode
// - polarity and level bits select trigger, sources 0/1
// - rise and fall enables select trigger, sources 2/3
// - flags stay set until software clears them
// - plain read gives live pins; alias gives latch
module fbp_port
    import fbp_pkg::*;
(
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    input  wire logic [fbp_pkg::ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [fbp_pkg::DATA_W-1:0]   s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [fbp_pkg::ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [fbp_pkg::DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    input  wire logic [fbp_pkg::NPINS-1:0]    port_pin_in,
    output logic [fbp_pkg::NPINS-1:0]         port_pin_out,
    output logic [fbp_pkg::NPINS-1:0]         port_pin_oe_n,
    output logic [fbp_pkg::NPINS-1:0]         port_pull_up_en,
    input  wire logic                         deep_standby,
    input  wire logic                         irq_accept,
    output logic [fbp_pkg::NPINS-1:0]         irq_request,
    output logic                              standby_wake,
    output logic                              light_standby,
    output logic                              timer0_count_pulse,
    output logic                              timer0_low_half_capture,
    output logic                              timer0_high_half_capture
);
    import fbp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////

    // address decode shared by the read and write paths
    function automatic fbp_reg_t fbp_decode(input logic [ADDR_W-1:0] addr);
        logic [IDX_W-1:0] idx;
        idx = addr[ADDR_W-1:2];
        if (idx == IDX_PORT)       fbp_decode = FBP_REG_PORT;
        else if (idx == IDX_CTL01) fbp_decode = FBP_REG_CTL01;
        else if (idx == IDX_CTL23) fbp_decode = FBP_REG_CTL23;
        else if (idx == IDX_INSEL) fbp_decode = FBP_REG_INSEL;
        else if (idx == IDX_LATCH) fbp_decode = FBP_REG_LATCH;
        else                       fbp_decode = FBP_REG_NONE;
    endfunction

    logic [7:0]        port_q;
    logic [7:0]        ctl01_q;
    logic [7:0]        ctl23_q;
    logic [7:0]        insel_q;
    logic [NPINS-1:0]  sync1_q;
    logic [NPINS-1:0]  sync2_q;
    logic [NPINS-1:0]  prev_q;
    logic              standby_q;
    logic              entry_lvl2_q;
    logic              wake_q;
    logic              light_q;
    logic              cnt_q;
    logic              lcap_q;
    logic              hcap_q;

    ////////////////////////////////////////////////////////////////////////////
    // register bus slave

    logic              aw_held_q;
    logic              w_held_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [7:0]        w_data_q;
    logic              w_lane0_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [DATA_W-1:0] rdata_q;
    logic [1:0]        rresp_q;

    // handshake and write decode
    wire               do_write  = aw_held_q & w_held_q & ~bvalid_q;
    wire fbp_reg_t     wr_sel    = fbp_decode(aw_addr_q);
    wire               wr_en     = do_write & w_lane0_q;
    wire               wr_port   = wr_en & ((wr_sel == FBP_REG_PORT) | (wr_sel == FBP_REG_LATCH));
    wire               wr_ctl01  = wr_en & (wr_sel == FBP_REG_CTL01);
    wire               wr_ctl23  = wr_en & (wr_sel == FBP_REG_CTL23);
    wire               wr_insel  = wr_en & (wr_sel == FBP_REG_INSEL);
    wire fbp_reg_t     rd_sel    = fbp_decode(s_axi_araddr);
    wire               ar_take   = s_axi_arvalid & ~rvalid_q;

    assign s_axi_awready = ~aw_held_q;
    assign s_axi_wready  = ~w_held_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // read data: port register shows live pins in the low nibble
    logic [7:0] rd_byte;
    always_comb begin
        unique case (rd_sel)
            FBP_REG_PORT:  rd_byte = {port_q[7:FLD_DIR], sync2_q};
            FBP_REG_LATCH: rd_byte = port_q;
            FBP_REG_CTL01: rd_byte = ctl01_q;
            FBP_REG_CTL23: rd_byte = ctl23_q;
            FBP_REG_INSEL: rd_byte = insel_q;
            default:       rd_byte = RST_REG;
        endcase
    end

    // write channel capture and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= RST_REG;
            w_lane0_q <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_held_q) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held_q) begin
                w_held_q  <= 1'b1;
                w_data_q  <= s_axi_wdata[7:0];
                w_lane0_q <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= (wr_sel == FBP_REG_NONE) ? RESP_SLVERR : RESP_OKAY;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q  <= 1'b0;
            end
        end
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {{(DATA_W-8){1'b0}}, rd_byte};
            rresp_q  <= (rd_sel == FBP_REG_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drivers

    // pin zero open-drain, others push-pull; types are wired, not options
    genvar gp;
    generate
        for (gp = 0; gp < NPINS; gp++) begin : g_drv
            if (gp == 0) begin : g_od
                assign port_pin_out[gp]  = 1'b0;
                assign port_pin_oe_n[gp] = ~(port_q[FLD_DIR+gp] & ~port_q[gp]);
            end else begin : g_pp
                assign port_pin_out[gp]  = port_q[gp];
                assign port_pin_oe_n[gp] = ~port_q[FLD_DIR+gp];
            end
            assign port_pull_up_en[gp] = port_q[gp];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // input sync and event detection

    logic [NPINS-1:0] rise;
    logic [NPINS-1:0] fall;
    logic [NPINS-1:0] hit;
    wire  [7:0]       ctl_of [NPINS];

    assign ctl_of[0] = ctl01_q;
    assign ctl_of[1] = ctl01_q;
    assign ctl_of[2] = ctl23_q;
    assign ctl_of[3] = ctl23_q;

    // pin two edges blocked by the level held at standby entry
    wire blk_rise2 = deep_standby & standby_q & entry_lvl2_q;
    wire blk_fall2 = deep_standby & standby_q & ~entry_lvl2_q;

    // per-pin trigger selection
    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi++) begin : g_det
            localparam int B = (gi % 2) * NIB_W;
            assign rise[gi] = sync2_q[gi] & ~prev_q[gi];
            assign fall[gi] = ~sync2_q[gi] & prev_q[gi];
            if (gi < 2) begin : g_lv
                wire pol = ctl_of[gi][B+FLD_SELA];
                wire lvl = ctl_of[gi][B+FLD_SELB];
                assign hit[gi] = lvl ? (sync2_q[gi] == pol)
                                     : (pol ? rise[gi] : fall[gi]);
            end else if (gi == 2) begin : g_e2
                assign hit[gi] = (ctl_of[gi][B+FLD_SELA] & rise[gi] & ~blk_rise2)
                               | (ctl_of[gi][B+FLD_SELB] & fall[gi] & ~blk_fall2);
            end else begin : g_e3
                assign hit[gi] = (ctl_of[gi][B+FLD_SELA] & rise[gi])
                               | (ctl_of[gi][B+FLD_SELB] & fall[gi]);
            end
        end
    endgenerate

    // synchroniser and history
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q  <= '0;
        end else begin
            sync1_q <= port_pin_in;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // standby entry level of pin two, caught at the entry edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            standby_q    <= 1'b0;
            entry_lvl2_q <= 1'b0;
        end else begin
            standby_q <= deep_standby;
            if (deep_standby && !standby_q)
                entry_lvl2_q <= sync2_q[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers; a hardware set wins over a software clear

    wire [7:0] set01 = (8'(hit[0]) << FLD_FLAG) | (8'(hit[1]) << (NIB_W + FLD_FLAG));
    wire [7:0] set23 = (8'(hit[2]) << FLD_FLAG) | (8'(hit[3]) << (NIB_W + FLD_FLAG));
    wire [7:0] ctl01_d = (wr_ctl01 ? w_data_q : ctl01_q) | set01;
    wire [7:0] ctl23_d = (wr_ctl23 ? w_data_q : ctl23_q) | set23;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_q  <= RST_REG;
            ctl01_q <= RST_REG;
            ctl23_q <= RST_REG;
            insel_q <= RST_REG;
        end else begin
            if (wr_port)
                port_q <= w_data_q;
            if (wr_insel)
                insel_q <= w_data_q;
            ctl01_q <= ctl01_d;
            ctl23_q <= ctl23_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // timer strobes, requests and wake

    wire [NPINS-1:0] flag = {ctl23_q[NIB_W+FLD_FLAG], ctl23_q[FLD_FLAG],
                             ctl01_q[NIB_W+FLD_FLAG], ctl01_q[FLD_FLAG]};
    wire [NPINS-1:0] ena  = {ctl23_q[NIB_W+FLD_EN], ctl23_q[FLD_EN],
                             ctl01_q[NIB_W+FLD_EN], ctl01_q[FLD_EN]};
    wire lvl0 = ctl01_q[FLD_SELB];
    wire lvl1 = ctl01_q[NIB_W+FLD_SELB];

    wire cnt_d  = insel_q[FLD_CNT_SEL]  ? hit[3] : hit[2];
    wire lcap_d = insel_q[FLD_LCAP_SEL] ? hit[0] : hit[2];
    wire hcap_d = insel_q[FLD_HCAP_SEL] ? hit[1] : hit[3];
    wire wake_d = (flag[0] & ena[0] & lvl0)
                | (flag[1] & ena[1] & lvl1)
                | (flag[2] & ena[2]);

    assign irq_request              = flag & ena;
    assign standby_wake             = wake_q;
    assign light_standby            = light_q;
    assign timer0_count_pulse       = cnt_q;
    assign timer0_low_half_capture  = lcap_q;
    assign timer0_high_half_capture = hcap_q;

    // registered strobes and standby state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q   <= 1'b0;
            lcap_q  <= 1'b0;
            hcap_q  <= 1'b0;
            wake_q  <= 1'b0;
            light_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            lcap_q <= lcap_d;
            hcap_q <= hcap_d;
            wake_q <= wake_d;
            if (irq_accept)
                light_q <= 1'b0;
            else if (wake_q && deep_standby)
                light_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_level0_active;
        ctl01_q[FLD_SELB] && (sync2_q[0] == ctl01_q[FLD_SELA]) && insel_q[FLD_LCAP_SEL];
    endsequence

    sequence s_pin2_count;
        hit[2] && !insel_q[FLD_CNT_SEL];
    endsequence

    a_open_drain_high: assert property (port_q[FLD_DIR] && port_q[0] |-> port_pin_oe_n[0] && !port_pin_out[0])
        else $error("pin zero drove high");

    a_push_pull_out: assert property (port_q[FLD_DIR+1] |-> !port_pin_oe_n[1] && port_pin_out[1] == port_q[1])
        else $error("pin one not driving its data bit");

    a_flag_sticky: assert property ($rose(ctl01_q[FLD_FLAG]) ##1 !wr_ctl01[*3] |-> ctl01_q[FLD_FLAG])
        else $error("source zero flag dropped without a write");

    a_level_capture_repeat: assert property (s_level0_active [*3] |-> lcap_q ##1 lcap_q)
        else $error("low capture not repeated during level");

    a_count_pulse: assert property (s_pin2_count |=> cnt_q)
        else $error("timer count pulse missing for pin two");

    a_edge_once: assert property (rise[3] && ctl23_q[NIB_W+FLD_SELA] |=> !hit[3])
        else $error("one edge produced two events");

    a_edge_no_wake: assert property (!lvl0 && !lvl1 && !(flag[2] && ena[2]) |=> !wake_q)
        else $error("wake from edge mode on pins zero or one");

    a_pin3_no_wake: assert property (flag[3] && ena[3] && !(flag[2] && ena[2])
                                     && !(flag[0] && ena[0]) && !(flag[1] && ena[1]) |=> !wake_q)
        else $error("pin three produced a wake");

    a_standby_block: assert property (deep_standby && standby_q && entry_lvl2_q && rise[2]
                                      && !ctl23_q[FLD_SELB] |-> !hit[2])
        else $error("blocked rising edge set source two flag");

    a_wake_from_flag: assert property (flag[2] && ena[2] |=> wake_q)
        else $error("wake missing for source two");

endmodule
`default_nettype wire

/* hw/fbp_pkg.sv */
`default_nettype none
package fbp_pkg;

    // bus geometry
    localparam int          ADDR_W        = 18;
    localparam int          DATA_W        = 32;
    localparam int          IDX_W         = 16;
    localparam int          NPINS         = 4;

    // register indices, byte address is four times the index
    localparam logic [15:0] IDX_PORT      = 16'hFE5C;
    localparam logic [15:0] IDX_CTL01     = 16'hFE5D;
    localparam logic [15:0] IDX_CTL23     = 16'hFE5E;
    localparam logic [15:0] IDX_INSEL     = 16'hFE5F;
    localparam logic [15:0] IDX_LATCH     = 16'hFE58;

    // reset values
    localparam logic [7:0]  RST_REG       = 8'h00;

    // per-source nibble layout inside the interrupt control registers
    localparam int          NIB_W         = 4;
    localparam int          FLD_EN        = 0;
    localparam int          FLD_FLAG      = 1;
    localparam int          FLD_SELB      = 2;
    localparam int          FLD_SELA      = 3;

    // port register layout
    localparam int          FLD_DIR       = 4;

    // input select register fields
    localparam int          FLD_CNT_SEL   = 0;
    localparam int          FLD_LCAP_SEL  = 6;
    localparam int          FLD_HCAP_SEL  = 7;

    // response codes
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef enum logic [2:0] {
        FBP_REG_NONE,
        FBP_REG_PORT,
        FBP_REG_CTL01,
        FBP_REG_CTL23,
        FBP_REG_INSEL,
        FBP_REG_LATCH
    } fbp_reg_t;

endpackage
`default_nettype wire

/* tb/fbp_board.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
// board-side pin model: resolves each pin from every driver
module fbp_board (
    input  wire logic       aclk,
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe_n,
    input  wire logic [3:0] pull_up,
    input  wire logic [3:0] brd_val,
    input  wire logic [3:0] brd_en,
    output logic [3:0]      pin_lvl
);
    logic [3:0] float_q = 4'h0;

    // an undriven, unpulled pin wanders every cycle
    always_ff @(posedge aclk) float_q <= ~float_q;

    // device drive beats board drive, which beats the pull-up
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (!pin_oe_n[i])
                pin_lvl[i] = pin_out[i];
            else if (brd_en[i])
                pin_lvl[i] = brd_val[i];
            else if (pull_up[i])
                pin_lvl[i] = 1'b1;
            else
                pin_lvl[i] = float_q[i];
        end
    end
endmodule
`default_nettype wire

/* tb/four_bit_port_with_ext_irq_test.sv */
`timescale 1ns/1ps
`default_nettype none
module four_bit_port_with_ext_irq_test;
    import fbp_pkg::*;
    typedef struct packed {
        logic [15:0] widx;
        logic [7:0]  wd;
        logic [15:0] ridx;
        logic [7:0]  rexp;
        logic [1:0]  rsp;
    } fbp_row_t;
    logic              aclk, aresetn;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic              awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready;
    logic [DATA_W-1:0] wdata, rdata, rd;
    logic [3:0]        wstrb, pin_in, pin_out, oe_n, pull_en, irq_req, brd_val, nib;
    logic [1:0]        bresp, rresp, rs;
    logic              deep_sb, irq_acc, wake, light_sb, cnt_p, lcap_p, hcap_p;
    int                error_cnt, cmp_count, n_cnt, n_lcap, n_hcap, s_c, s_l, s_h;
    fbp_row_t          rows [8];

    // clock, 100 ns period
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    fbp_port DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_pin_in(pin_in),
        .port_pin_out(pin_out), .port_pin_oe_n(oe_n), .port_pull_up_en(pull_en), .deep_standby(deep_sb),
        .irq_accept(irq_acc), .irq_request(irq_req), .standby_wake(wake), .light_standby(light_sb),
        .timer0_count_pulse(cnt_p), .timer0_low_half_capture(lcap_p), .timer0_high_half_capture(hcap_p));

    fbp_board board (.aclk(aclk), .pin_out(pin_out), .pin_oe_n(oe_n), .pull_up(pull_en),
        .brd_val(brd_val), .brd_en(4'hF), .pin_lvl(pin_in));

    // tally the timer strobes
    always @(posedge aclk) begin
        n_cnt  += int'(cnt_p === 1'b1);
        n_lcap += int'(lcap_p === 1'b1);
        n_hcap += int'(hcap_p === 1'b1);
    end

    ////////////////////////////////////////////////////////////////
    // helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic chk_v(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_r(input logic [1:0] g, input logic [1:0] e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: resp %h expected %h", $time, g, e);
        end
    endtask

    // one write: address and data offered together, each released when taken
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic aw_d;
        logic w_d;
        awaddr  <= {idx, 2'b00};
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        aw_d = 1'b0;
        w_d  = 1'b0;
        while (!(aw_d && w_d)) begin
            @(posedge aclk);
            if (!aw_d && awready === 1'b1) begin
                aw_d = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_d && wready === 1'b1) begin
                w_d = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        rs = bresp;
    endtask

    task automatic rdr(input logic [15:0] idx);
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rd = rdata;
        rs = rresp;
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // hang guard, well past the expected few hundred cycles
    initial begin
        cyc(20000);
        error_cnt++;
        test_done;
    end

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rows = '{'{IDX_CTL01, 8'h99, IDX_CTL01, 8'h99, RESP_OKAY}, '{IDX_CTL23, 8'hDD, IDX_CTL23, 8'hDD, RESP_OKAY},
                 '{IDX_INSEL, 8'h3E, IDX_INSEL, 8'h3E, RESP_OKAY}, '{IDX_PORT, 8'h0A, IDX_PORT, 8'h0F, RESP_OKAY},
                 '{IDX_PORT, 8'h0A, IDX_LATCH, 8'h0A, RESP_OKAY}, '{IDX_PORT, 8'hF0, IDX_PORT, 8'hF0, RESP_OKAY},
                 '{16'hFE60, 8'h55, 16'hFE60, 8'h00, RESP_SLVERR}, '{IDX_PORT, 8'h00, IDX_PORT, 8'h0F, RESP_OKAY}};
        {aresetn, awvalid, wvalid, bready, arvalid, rready, deep_sb, irq_acc} = 8'h00;
        {awaddr, araddr, wdata} = '0;
        wstrb   = 4'hF;
        brd_val = 4'hF;
        cyc(8);
        aresetn <= 1'b1;
        cyc(1);
        chk_v({oe_n, pull_en, pin_out}, 32'hF00);
        // table of plain register accesses
        foreach (rows[i]) begin
            wr(rows[i].widx, rows[i].wd);
            chk_r(rs, rows[i].rsp);
            cyc(2); // live pin levels pass two sync stages
            rdr(rows[i].ridx);
            chk_v(rd, {24'h0, rows[i].rexp});
            chk_r(rs, rows[i].rsp);
        end
        // pin drive types
        wr(IDX_PORT, 8'hFF);
        chk_v({oe_n, pull_en, pin_out[3:1]}, 32'h0FF);
        wr(IDX_PORT, 8'h90);
        chk_v({oe_n, pull_en, pin_out}, 32'h600);
        wr(IDX_PORT, 8'h00);
        cyc(4); // let the released pins settle before mode changes
        // every trigger code of source zero, judged by its flag
        for (int m = 0; m < 4; m++) begin
            nib = {m[1:0], 2'b00};
            wr(IDX_CTL01, {4'h0, nib});
            cyc(6);
            rdr(IDX_CTL01);
            chk_v(rd, {28'h0, nib | {2'b0, m == 3, 1'b0}});
            wr(IDX_CTL01, {4'h0, nib});
            brd_val[0] <= 1'b0;
            cyc(8);
            rdr(IDX_CTL01);
            chk_v(rd, {28'h0, nib | {2'b0, m != 2, 1'b0}});
            wr(IDX_CTL01, {4'h0, nib});
            brd_val[0] <= 1'b1;
            cyc(8);
            rdr(IDX_CTL01);
            chk_v(rd, {28'h0, nib | {2'b0, m != 0, 1'b0}});
        end
        // level mode repeats the capture strobes each cycle
        wr(IDX_CTL01, 8'h44);
        wr(IDX_INSEL, 8'hC0);
        cyc(3);
        s_l = n_lcap;
        s_h = n_hcap;
        brd_val[1:0] <= 2'b00;
        cyc(10);
        brd_val[1:0] <= 2'b11;
        cyc(8);
        chk_v(n_lcap - s_l, 10);
        chk_v(n_hcap - s_h, 10);
        rdr(IDX_CTL01);
        chk_v(rd, 32'h66);
        // every edge code of source two: count and low capture
        wr(IDX_INSEL, 8'h00);
        for (int m = 0; m < 4; m++) begin
            wr(IDX_CTL23, {4'h0, m[1:0], 2'b00});
            cyc(3);
            s_c = n_cnt;
            s_l = n_lcap;
            brd_val[2] <= 1'b0;
            cyc(8);
            chk_v(n_cnt - s_c, m[0]);
            brd_val[2] <= 1'b1;
            cyc(8);
            chk_v(n_cnt - s_c, m[0] + m[1]);
            chk_v(n_lcap - s_l, m[0] + m[1]);
        end
        // source three both edges drives count and high capture
        wr(IDX_INSEL, 8'h01);
        wr(IDX_CTL23, 8'hC0);
        cyc(3);
        s_c = n_cnt;
        s_h = n_hcap;
        brd_val[3] <= 1'b0;
        cyc(8);
        brd_val[3] <= 1'b1;
        cyc(8);
        chk_v(n_cnt - s_c, 2);
        chk_v(n_hcap - s_h, 2);
        rdr(IDX_CTL23);
        chk_v(rd, 32'hE0);
        // standby entered high: a rising edge must not set the flag
        wr(IDX_CTL23, 8'h09);
        cyc(3);
        deep_sb <= 1'b1;
        cyc(3);
        brd_val[2] <= 1'b0;
        cyc(6);
        brd_val[2] <= 1'b1;
        cyc(8);
        chk_v({wake, irq_req}, 32'h00);
        wr(IDX_CTL23, 8'h0D);
        brd_val[2] <= 1'b0;
        cyc(8);
        chk_v({wake, light_sb, irq_req}, 32'h34);
        deep_sb <= 1'b0;
        cyc(2);
        irq_acc <= 1'b1;
        cyc(1);
        irq_acc <= 1'b0;
        cyc(2);
        chk_v(light_sb, 32'h0);
        brd_val[2] <= 1'b1;
        // edge mode on pin zero and pin three never wake
        wr(IDX_CTL23, 8'hD0);
        wr(IDX_CTL01, 8'h01);
        cyc(2);
        deep_sb <= 1'b1;
        cyc(3);
        brd_val <= 4'b0110;
        cyc(6);
        brd_val <= 4'hF;
        cyc(8);
        chk_v({wake, irq_req}, 32'h09);
        wr(IDX_CTL23, 8'h00);
        wr(IDX_CTL01, 8'h05);
        brd_val[0] <= 1'b0;
        cyc(8);
        chk_v(wake, 32'h1);
        brd_val[0] <= 1'b1;
        deep_sb <= 1'b0;
        // reset in mid-run restores every register
        wr(IDX_INSEL, 8'h5A);
        aresetn <= 1'b0;
        cyc(2);
        aresetn <= 1'b1;
        cyc(3);
        for (int i = 0; i < 4; i++) begin
            rdr(IDX_PORT + 16'(i));
            chk_v(rd, (i == 0) ? 32'h0F : 32'h0);
        end
        test_done;
    end
endmodule
`default_nettype wire
